// ### rtl/adcav_pkg.sv
// Shared constants and types of the converter averaging control
package adcav_pkg;
  localparam int RES_W = 12;        // Conversion result width
  localparam int OUT_W = 16;        // Result register width
  localparam int AVG_W = 3;         // Averaging select width, N = 2**sel
  localparam int CH_W  = 4;         // Scan channel offset width

  localparam logic [OUT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [CH_W-1:0]  CHAN_RST   = 4'h0;

  typedef enum logic [1:0] {
    ADCAV_IDLE = 2'b00,
    ADCAV_CONV = 2'b01,
    ADCAV_AVG  = 2'b10
  } adcav_state_t;
endpackage

// ### rtl/adcav_accum.sv
// Sample accumulator of the averaging control
`timescale 1ns/1ps
module adcav_accum #(
  parameter int W = 19
) (
  input  wire logic         mclk,    // Peripheral clock
  input  wire logic         rst_n,   // Asynchronous reset, active low
  input  wire logic         clk_en,  // Freezes the sum while low
  input  wire logic         clr,     // Empties the sum
  input  wire logic         add,     // Adds din to the sum
  input  wire logic [W-1:0] din,     // Extended, corrected sample
  output logic      [W-1:0] acc_q    // Running sum
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (clk_en) begin
      if (clr) begin
        acc_q <= '0;
      end else if (add) begin
        acc_q <= acc_q + din;
      end
    end
  end
endmodule

// ### rtl/adcav_ctrl.sv
// Converter averaging, scan stepping and start control
`timescale 1ns/1ps
module adcav_ctrl #(
  parameter int RES_W = adcav_pkg::RES_W,
  parameter int AVG_W = adcav_pkg::AVG_W,
  parameter int CH_W  = adcav_pkg::CH_W
) (
  input  wire logic                        mclk,         // Peripheral clock
  input  wire logic                        rst_n,        // Asynchronous reset
  input  wire logic                        clk_en,       // Freezes all state while low
  input  wire logic                        enable,       // Converter enable, low flushes
  input  wire logic                        free_run,     // Free-running conversions
  input  wire logic                        start_set,    // Software sets start bit
  input  wire logic                        event_en,     // Event trigger enable
  input  wire logic                        event_trig,   // Incoming event pulse
  input  wire logic                        scan_en,      // Channel scan enable
  input  wire logic [CH_W-1:0]             scan_last,    // Last scan channel offset
  input  wire logic [AVG_W-1:0]            avg_sel,      // Average of 2**avg_sel
  input  wire logic                        unsigned_md,  // Unsigned mode
  input  wire logic                        offset_en,    // Offset correction on, unsigned mode only
  input  wire logic [RES_W-1:0]            offset_val,   // Offset to remove
  input  wire logic                        done_clr,     // Clears the done flag
  input  wire logic                        sample_done,  // Sampler result valid
  input  wire logic [RES_W-1:0]            sample_data,  // Sampler result
  output logic                             sample_req_q, // Starts one conversion
  output logic                             start_q,      // Start bit
  output logic                             busy_q,       // Sequence running
  output logic [CH_W-1:0]                  chan_q,       // Scan channel offset
  output logic [adcav_pkg::OUT_W-1:0]      result_q,     // Averaged result
  output logic                             avg_done_q    // End of averaging flag
);
  localparam int OUT_W = adcav_pkg::OUT_W;
  localparam int CNT_W = (1 << AVG_W) - 1;
  localparam int ACC_W = RES_W + CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [OUT_W-1:0] avg_fn(input logic [ACC_W-1:0] acc,
                                               input logic [AVG_W-1:0] sel,
                                               input logic             uns);
    logic [ACC_W-1:0] sh;
    sh = uns ? (acc >> sel) : ACC_W'($signed(acc) >>> sel);
    avg_fn = uns ? OUT_W'(sh) : OUT_W'($signed(sh));
  endfunction

  function automatic logic [ACC_W-1:0] corr_fn(input logic [RES_W-1:0] d,
                                               input logic [RES_W-1:0] off,
                                               input logic             uns,
                                               input logic             oen);
    logic [RES_W-1:0] v;
    v = d;
    if (uns && oen) begin
      v = (d > off) ? RES_W'(d - off) : '0;
    end
    corr_fn = uns ? ACC_W'(v) : ACC_W'($signed(v));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  adcav_pkg::adcav_state_t st_q;
  adcav_pkg::adcav_state_t st_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        cnt_last;
  logic [ACC_W-1:0]        acc_q;
  logic                    fr_mode_q;
  logic                    fr_stop;
  logic                    trig;
  logic                    add;
  logic                    last;
  logic                    in_avg;

  assign cnt_last = CNT_W'((1 << avg_sel) - 1);
  assign last     = (cnt_q == cnt_last);
  assign fr_stop  = fr_mode_q && !free_run;
  assign trig     = start_q || (event_en && event_trig) || free_run;
  assign add      = enable && (st_q == adcav_pkg::ADCAV_CONV) && sample_done && !fr_stop;
  assign in_avg   = enable && (st_q == adcav_pkg::ADCAV_AVG);

  always_comb begin
    st_d = st_q;
    if (!enable) begin
      st_d = adcav_pkg::ADCAV_IDLE;
    end else begin
      case (st_q)
        adcav_pkg::ADCAV_IDLE: begin
          if (trig) begin
            st_d = adcav_pkg::ADCAV_CONV;
          end
        end
        adcav_pkg::ADCAV_CONV: begin
          if (fr_stop) begin
            st_d = adcav_pkg::ADCAV_IDLE;
          end else if (sample_done && last) begin
            st_d = adcav_pkg::ADCAV_AVG;
          end
        end
        adcav_pkg::ADCAV_AVG: st_d = adcav_pkg::ADCAV_IDLE;
        default:              st_d = adcav_pkg::ADCAV_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= adcav_pkg::ADCAV_IDLE;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      st_q   <= st_d;
      busy_q <= (st_d != adcav_pkg::ADCAV_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion requests: first from the trigger, the rest from each result but the last
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_req_q <= 1'b0;
    end else if (clk_en) begin
      sample_req_q <= (enable && st_q == adcav_pkg::ADCAV_IDLE && trig) ||
                      (add && !last);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else if (clk_en) begin
      if (start_set) begin
        start_q <= 1'b1;
      end else if (!enable || st_q == adcav_pkg::ADCAV_IDLE) begin
        start_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_mode_q <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        fr_mode_q <= 1'b0;
      end else if (st_q == adcav_pkg::ADCAV_IDLE && trig) begin
        fr_mode_q <= free_run && !start_q && !(event_en && event_trig);
      end
    end
  end

  // Count survives a free-run stop; disabling or the last sample of an average empties it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (!enable) begin
        cnt_q <= '0;
      end else if (add) begin
        cnt_q <= last ? '0 : cnt_q + 1'b1;
      end
    end
  end

  adcav_accum #(
    .W (ACC_W)
  ) u_accum (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clr    (!enable || in_avg),
    .add    (add),
    .din    (corr_fn(sample_data, offset_val, unsigned_md, offset_en)),
    .acc_q  (acc_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= adcav_pkg::RESULT_RST;
    end else if (clk_en && in_avg) begin
      result_q <= avg_fn(acc_q, avg_sel, unsigned_md);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= adcav_pkg::CHAN_RST;
    end else if (clk_en) begin
      if (!enable) begin
        chan_q <= adcav_pkg::CHAN_RST;
      end else if (in_avg && scan_en) begin
        chan_q <= (chan_q >= scan_last) ? '0 : chan_q + 1'b1;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avg_done_q <= 1'b0;
    end else if (clk_en) begin
      if (in_avg) begin
        avg_done_q <= 1'b1;
      end else if (done_clr || !enable) begin
        avg_done_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_start_clr;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && enable && !start_set && start_q && st_q == adcav_pkg::ADCAV_IDLE
      |=> !start_q && sample_req_q;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start bit not cleared");

  property p_next_req;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && add && !last |=> sample_req_q && st_q == adcav_pkg::ADCAV_CONV;
  endproperty
  a_next_req: assert property (p_next_req) else $error("no follow-on conversion");

  property p_done_after_avg;
    @(posedge mclk) disable iff (!rst_n)
    $rose(avg_done_q) |-> $past(in_avg) && $past(clk_en) && $past(cnt_q) == '0;
  endproperty
  a_done_after_avg: assert property (p_done_after_avg) else $error("early done flag");

  property p_event_start;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && enable && st_q == adcav_pkg::ADCAV_IDLE && event_en && event_trig
      |=> sample_req_q ##0 busy_q;
  endproperty
  a_event_start: assert property (p_event_start) else $error("event ignored");

  property p_zero_fill;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && in_avg && unsigned_md |=> result_q[OUT_W-1:RES_W] == '0;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("upper bits not zero");

  property p_fr_keep;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && enable && st_q == adcav_pkg::ADCAV_CONV && fr_stop
      |=> st_q == adcav_pkg::ADCAV_IDLE && acc_q == $past(acc_q) && cnt_q == $past(cnt_q);
  endproperty
  a_fr_keep: assert property (p_fr_keep) else $error("free-run stop lost sum");

  property p_sat_zero;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && add && unsigned_md && offset_en && sample_data <= offset_val
      |=> acc_q == $past(acc_q);
  endproperty
  a_sat_zero: assert property (p_sat_zero) else $error("offset not saturated");

  property p_chan_hold;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && enable && !in_avg |=> chan_q == $past(chan_q);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid-average");

  property p_result;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && in_avg
      |=> result_q == avg_fn($past(acc_q), $past(avg_sel), $past(unsigned_md)) && acc_q == '0;
  endproperty
  a_result: assert property (p_result) else $error("wrong averaged result");
endmodule

// ### bench/tb_top.sv
// Self-checking testbench of the converter averaging control
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic                           mclk = 1'b0;
  logic                           rst_n = 1'b0;
  logic                           clk_en = 1'b1;
  logic                           enable = 1'b0;
  logic                           free_run = 1'b0;
  logic                           start_set = 1'b0;
  logic                           event_en = 1'b0;
  logic                           event_trig = 1'b0;
  logic                           scan_en = 1'b0;
  logic [adcav_pkg::CH_W-1:0]     scan_last = 4'h0;
  logic [adcav_pkg::AVG_W-1:0]    avg_sel = 3'h0;
  logic                           unsigned_md = 1'b1;
  logic                           offset_en = 1'b0;
  logic [adcav_pkg::RES_W-1:0]    offset_val = 12'h000;
  logic                           done_clr = 1'b0;
  logic                           sample_done = 1'b0;
  logic [adcav_pkg::RES_W-1:0]    sample_data = 12'h000;
  logic [adcav_pkg::RES_W-1:0]    dmask = 12'hfff;
  logic [adcav_pkg::RES_W-1:0]    d;
  logic [adcav_pkg::CH_W-1:0]     ch = 4'h0;
  logic                           sample_req_q;
  logic                           start_q;
  logic                           busy_q;
  logic                           avg_done_q;
  logic [adcav_pkg::CH_W-1:0]     chan_q;
  logic [adcav_pkg::OUT_W-1:0]    result_q;
  int                             failures = 0;
  int                             compares = 0;
  int                             seed = 32'hc950a146;
  int                             reqs = 0;
  int                             taken = 0;
  int                             dly = -1;
  int                             i;
  int                             k;
  longint                         sum = 0;

  adcav_ctrl dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .enable(enable),
    .free_run(free_run), .start_set(start_set), .event_en(event_en),
    .event_trig(event_trig), .scan_en(scan_en), .scan_last(scan_last),
    .avg_sel(avg_sel), .unsigned_md(unsigned_md), .offset_en(offset_en),
    .offset_val(offset_val), .done_clr(done_clr), .sample_done(sample_done),
    .sample_data(sample_data), .sample_req_q(sample_req_q), .start_q(start_q),
    .busy_q(busy_q), .chan_q(chan_q), .result_q(result_q), .avg_done_q(avg_done_q));

  initial forever #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Corrected sample value as the accumulator should see it
  function automatic longint corr(logic [11:0] v);
    if (unsigned_md !== 1'b1) return longint'($signed(v));
    if (offset_en === 1'b1) return (v > offset_val) ? longint'(v - offset_val) : 0;
    return longint'(v);
  endfunction

  // Sampler: answers each request once, after 0 to 2 idle cycles
  always @(posedge mclk) begin
    if (sample_done === 1'b1) taken++;
    sample_done <= 1'b0;
    if (dly == 0) begin
      d = 12'($random(seed)) & dmask;
      sample_done <= 1'b1;
      sample_data <= d;
      sum += corr(d);
    end
    if (dly >= 0) dly--;
    if (sample_req_q === 1'b1) begin
      reqs++;
      dly = int'($unsigned($random(seed)) % 3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One average: 0 start bit, 1 event, 2 free run
  task automatic run_avg(input int kind);
    int n;
    int j;
    @(posedge mclk);
    done_clr <= 1'b1;
    @(posedge mclk);
    done_clr <= 1'b0;
    n = 1 << avg_sel;
    @(negedge mclk);
    sum = 0;
    taken = 0;
    reqs = 0;
    @(posedge mclk);
    start_set <= (kind == 0);
    event_en <= (kind == 1);
    event_trig <= (kind == 1);
    free_run <= (kind == 2);
    @(posedge mclk);
    start_set <= 1'b0;
    event_trig <= 1'b0;
    @(negedge mclk);
    if (kind == 0) `CHK(start_q, 1'b1);
    for (j = 0; j < 2000 && avg_done_q !== 1'b1; j++) begin
      @(negedge mclk);
      if (taken < n) begin
        `CHK(avg_done_q, 1'b0);
        `CHK(chan_q, ch);
      end
    end
    if (j >= 2000) begin
      failures++;
      end_sim();
    end
    if (scan_en) ch = (ch >= scan_last) ? 4'h0 : ch + 4'h1;
    `CHK(chan_q, ch);
    `CHK(reqs, n);
    `CHK(result_q, 16'(sum >>> avg_sel));
    if (kind == 0) `CHK(start_q, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    enable <= 1'b1;
    for (i = 0; i < 14; i++) begin
      @(posedge mclk);
      avg_sel <= (i == 0) ? 3'h7 : 3'($unsigned($random(seed)) % 5);
      unsigned_md <= (i < 2) ? 1'b1 : 1'($random(seed));
      offset_en <= (i == 1) ? 1'b1 : 1'($random(seed));
      offset_val <= (i == 1) ? 12'h080 : 12'($random(seed));
      dmask <= (i % 3 == 1) ? 12'h0ff : 12'hfff;
      scan_en <= (i > 3) ? 1'($random(seed)) : 1'b1;
      scan_last <= (i > 3) ? 4'($unsigned($random(seed)) % 4) : 4'h2;
      run_avg(i % 2);
    end
    // Free run, then drop it mid-average and flush by disabling
    @(posedge mclk);
    avg_sel <= 3'h2;
    run_avg(2);
    @(negedge mclk);
    taken = 0;
    for (k = 0; k < 100 && taken == 0; k++) @(negedge mclk);
    `CHK(taken > 0, 1'b1);
    if (taken == 0) end_sim();
    @(posedge mclk);
    free_run <= 1'b0;
    repeat (10) @(negedge mclk);
    `CHK(busy_q, 1'b0);
    @(posedge mclk);
    enable <= 1'b0;
    @(posedge mclk);
    enable <= 1'b1;
    @(negedge mclk);
    `CHK(avg_done_q, 1'b0);
    `CHK(chan_q, 4'h0);
    // A start request while frozen must leave no trace
    @(posedge mclk);
    clk_en <= 1'b0;
    start_set <= 1'b1;
    @(posedge mclk);
    start_set <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(start_q, 1'b0);
    `CHK(busy_q, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    ch = 4'h0;
    run_avg(0);
    end_sim();
  end
endmodule
